// ===== hrcs_top.sv
// high-frequency reference clock switch with axi4-lite registers
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module hrcs_top
  import hrcs_pkg::*;
#(
  parameter int WU_BITS = 14,
  parameter int CMP_BITS = 8
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_osc_tick,
  input wire logic ext_osc_tick,
  output logic hf_reference_clock,
  output logic osc_pin_function_select,
  output logic int_osc_enable,
  output logic ext_osc_enable,
  output logic sysclk_reset,
  output logic warmup_done_interrupt
);

  // ********************************
  // parameter check
  // ********************************
  if (CMP_BITS < 1 || WU_BITS <= CMP_BITS || WU_BITS > 31)
  begin : g_bad_params
    $error("hrcs_top: warm-up widths not supported");
  end

  // ********************************
  // state
  // ********************************
  hrcs_ctrl_t ctrl, next_ctrl;
  hrcs_sw_state_t sw_state, next_sw_state;
  logic cur_src, next_cur_src;
  logic [1:0] sw_cnt, next_sw_cnt;
  logic wu_active, next_wu_active;
  logic wu_src, next_wu_src;
  logic [WU_BITS-1:0] wu_cnt, next_wu_cnt;
  logic [CMP_BITS-1:0] wu_cmp, next_wu_cmp;
  logic [1:0] irq_status, next_irq_status;
  logic [1:0] irq_mask, next_irq_mask;
  logic clk_rst, next_clk_rst;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == HRCS_OFS_CTRL) || (a == HRCS_OFS_STATUS) || (a == HRCS_OFS_WUCMP) ||
                 (a == HRCS_OFS_IRQ_STATUS) || (a == HRCS_OFS_IRQ_MASK);
  endfunction : reg_mapped

  logic wr_fire;
  logic rd_fire;
  logic old_tick;
  logic new_tick;
  logic wu_tick;
  logic wu_done;
  logic rst_event;
  logic sw_busy;
  hrcs_ctrl_t wr_ctrl;

  // nothing is taken while the clock enable freezes the state
  assign wr_fire = ce && s_axi_awvalid && s_axi_wvalid && !bvalid;
  assign rd_fire = ce && s_axi_arvalid && !rvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  assign old_tick = cur_src ? ext_osc_tick : int_osc_tick;
  assign new_tick = cur_src ? int_osc_tick : ext_osc_tick;
  assign wu_tick = wu_src ? ext_osc_tick : int_osc_tick;
  assign wu_done = wu_active && (wu_cnt[WU_BITS-1 -: CMP_BITS] == wu_cmp);
  // change pending, in progress or in its hold-off
  assign sw_busy = (sw_state != HRCS_IDLE) || (ctrl.ref_source_select != cur_src);

  // ********************************
  // control register and clock fault detection
  // ********************************
  always_comb
  begin
    wr_ctrl = ctrl;
    rst_event = 1'b0;
    if (wr_fire && s_axi_awaddr == HRCS_OFS_CTRL && s_axi_wstrb[0])
    begin
      wr_ctrl = hrcs_ctrl_t'(s_axi_wdata[4:0]);
      if (ctrl.low_speed_select)
      begin
        wr_ctrl.ref_source_select = ctrl.ref_source_select;
      end
    end
    if (wr_ctrl.ext_osc_enable && !ctrl.ext_osc_enable && !wr_ctrl.osc_pin_function_select)
    begin
      rst_event = 1'b1;
    end
    if (sw_busy && !wr_ctrl.int_osc_enable)
    begin
      rst_event = 1'b1;
    end
    if (sw_busy && !wr_ctrl.ext_osc_enable)
    begin
      rst_event = 1'b1;
    end
    if ((cur_src && !wr_ctrl.ext_osc_enable) || (!cur_src && !wr_ctrl.int_osc_enable))
    begin
      rst_event = 1'b1;
    end
  end

  // ********************************
  // next-state logic
  // ********************************
  always_comb
  begin
    next_ctrl = wr_ctrl;
    next_sw_state = sw_state;
    next_cur_src = cur_src;
    next_sw_cnt = sw_cnt;
    next_wu_active = wu_active;
    next_wu_src = wu_src;
    next_wu_cnt = wu_cnt;
    next_wu_cmp = wu_cmp;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_clk_rst = rst_event;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    // source switch sequencer
    case (sw_state)
      HRCS_IDLE:
      begin
        if (ctrl.ref_source_select != cur_src)
        begin
          next_sw_state = HRCS_OLD;
          next_sw_cnt = 2'h0;
        end
      end
      HRCS_OLD:
      begin
        if (old_tick)
        begin
          next_sw_cnt = sw_cnt + 2'h1;
          if (sw_cnt + 2'h1 == HRCS_OLD_TICKS)
          begin
            next_sw_state = HRCS_GAP;
            next_sw_cnt = 2'h0;
          end
        end
      end
      HRCS_GAP:
      begin
        if (new_tick)
        begin
          next_sw_cnt = sw_cnt + 2'h1;
          if (sw_cnt + 2'h1 == HRCS_NEW_TICKS)
          begin
            next_sw_state = HRCS_HOLD;
            next_cur_src = ~cur_src;
            next_sw_cnt = 2'h0;
          end
        end
      end
      HRCS_HOLD:
      begin
        if (old_tick)
        begin
          next_sw_cnt = sw_cnt + 2'h1;
          if (sw_cnt + 2'h1 == HRCS_HOLD_TICKS)
          begin
            next_sw_state = HRCS_IDLE;
          end
        end
      end
      default:
      begin
        next_sw_state = HRCS_IDLE;
      end
    endcase
    // warm-up counter, started only on a rising enable
    if (wu_active && !wu_done && wu_tick)
    begin
      next_wu_cnt = wu_cnt + 1'b1;
    end
    if (wu_done)
    begin
      next_wu_active = 1'b0;
      next_irq_status[HRCS_IRQ_WUDONE_BIT] = 1'b1;
    end
    if (wr_ctrl.ext_osc_enable && !ctrl.ext_osc_enable)
    begin
      next_wu_active = 1'b1;
      next_wu_src = 1'b1;
      next_wu_cnt = '0;
    end
    else if (wr_ctrl.int_osc_enable && !ctrl.int_osc_enable)
    begin
      next_wu_active = 1'b1;
      next_wu_src = 1'b0;
      next_wu_cnt = '0;
    end
    // register writes
    if (wr_fire)
    begin
      next_bvalid = 1'b1;
      next_bresp = reg_mapped(s_axi_awaddr) ? HRCS_RESP_OKAY : HRCS_RESP_SLVERR;
      if (s_axi_awaddr == HRCS_OFS_WUCMP && s_axi_wstrb[0])
      begin
        next_wu_cmp = s_axi_wdata[CMP_BITS-1:0];
      end
      if (s_axi_awaddr == HRCS_OFS_IRQ_MASK && s_axi_wstrb[0])
      begin
        next_irq_mask = s_axi_wdata[1:0];
      end
      if (s_axi_awaddr == HRCS_OFS_IRQ_STATUS && s_axi_wstrb[0])
      begin
        // a set in the same cycle wins over the clear
        next_irq_status = next_irq_status & ~s_axi_wdata[1:0];
        if (wu_done)
        begin
          next_irq_status[HRCS_IRQ_WUDONE_BIT] = 1'b1;
        end
      end
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // register reads
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp = reg_mapped(s_axi_araddr) ? HRCS_RESP_OKAY : HRCS_RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        HRCS_OFS_CTRL: next_rdata[4:0] = ctrl;
        HRCS_OFS_STATUS: next_rdata[3:0] = {clk_rst, wu_active, sw_state != HRCS_IDLE, cur_src};
        HRCS_OFS_WUCMP: next_rdata[CMP_BITS-1:0] = wu_cmp;
        HRCS_OFS_IRQ_STATUS: next_rdata[1:0] = irq_status;
        HRCS_OFS_IRQ_MASK: next_rdata[1:0] = irq_mask;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    // system clock reset reinitialises the clock control
    if (rst_event)
    begin
      next_ctrl = HRCS_CTRL_RESET;
      next_cur_src = 1'b0;
      next_sw_state = HRCS_IDLE;
      next_sw_cnt = 2'h0;
      next_wu_active = 1'b0;
      next_wu_src = 1'b0;
      next_wu_cnt = '0;
      next_wu_cmp = CMP_BITS'(HRCS_WUCMP_RESET);
      next_irq_status[HRCS_IRQ_CLKRST_BIT] = 1'b1;
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= HRCS_CTRL_RESET;
      sw_state <= HRCS_IDLE;
      cur_src <= 1'b0;
      sw_cnt <= 2'h0;
      wu_active <= 1'b0;
      wu_src <= 1'b0;
      wu_cnt <= '0;
      wu_cmp <= CMP_BITS'(HRCS_WUCMP_RESET);
      irq_status <= 2'h0;
      irq_mask <= HRCS_IRQ_MASK_RESET;
      clk_rst <= 1'b0;
      bvalid <= 1'b0;
      bresp <= HRCS_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= HRCS_RESP_OKAY;
    end
    else if (ce)
    begin
      ctrl <= next_ctrl;
      sw_state <= next_sw_state;
      cur_src <= next_cur_src;
      sw_cnt <= next_sw_cnt;
      wu_active <= next_wu_active;
      wu_src <= next_wu_src;
      wu_cnt <= next_wu_cnt;
      wu_cmp <= next_wu_cmp;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      clk_rst <= next_clk_rst;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ********************************
  // outputs
  // ********************************
  // reference follows the old clock until the gap, is stopped in the gap
  assign hf_reference_clock = (sw_state == HRCS_GAP) ? 1'b0 : old_tick;
  assign osc_pin_function_select = ctrl.osc_pin_function_select;
  assign int_osc_enable = ctrl.int_osc_enable;
  assign ext_osc_enable = ctrl.ext_osc_enable;
  assign sysclk_reset = clk_rst;
  assign warmup_done_interrupt = |(irq_status & irq_mask);

endmodule : hrcs_top

// ===== hrcs_pkg.sv
// package of constants and types for the high-frequency reference clock switch
package hrcs_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [7:0] HRCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] HRCS_OFS_STATUS = 8'h04;
  localparam logic [7:0] HRCS_OFS_WUCMP = 8'h08;
  localparam logic [7:0] HRCS_OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] HRCS_OFS_IRQ_MASK = 8'h10;

  // ********************************
  // field positions
  // ********************************
  localparam int HRCS_CTRL_PINSEL_BIT = 0;
  localparam int HRCS_CTRL_INTEN_BIT = 1;
  localparam int HRCS_CTRL_EXTEN_BIT = 2;
  localparam int HRCS_CTRL_SRCSEL_BIT = 3;
  localparam int HRCS_CTRL_SLOW_BIT = 4;
  localparam int HRCS_IRQ_WUDONE_BIT = 0;
  localparam int HRCS_IRQ_CLKRST_BIT = 1;

  // ********************************
  // reset values and timing
  // ********************************
  localparam logic [7:0] HRCS_WUCMP_RESET = 8'h66;
  localparam logic [1:0] HRCS_IRQ_MASK_RESET = 2'h0;
  // old-clock periods before the hand-over gap
  localparam logic [1:0] HRCS_OLD_TICKS = 2'h2;
  // new-clock periods of the gap (2.5 rounded down to whole ticks)
  localparam logic [1:0] HRCS_NEW_TICKS = 2'h2;
  // new-clock periods software must wait before stopping the old oscillator
  localparam logic [1:0] HRCS_HOLD_TICKS = 2'h2;
  localparam logic [1:0] HRCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] HRCS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic low_speed_select;
    logic ref_source_select;
    logic ext_osc_enable;
    logic int_osc_enable;
    logic osc_pin_function_select;
  } hrcs_ctrl_t;

  localparam hrcs_ctrl_t HRCS_CTRL_RESET = 5'h02;

  typedef enum {HRCS_IDLE, HRCS_OLD, HRCS_GAP, HRCS_HOLD} hrcs_sw_state_t;

endpackage : hrcs_pkg

// ===== hrcs_props.sv
// port assertions for the reference clock switch
`timescale 1ns/1ps
module hrcs_props
  import hrcs_pkg::*;
#(
  parameter int WU_BITS = 14,
  parameter int CMP_BITS = 8
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_osc_tick,
  input wire logic ext_osc_tick,
  input wire logic hf_reference_clock,
  input wire logic osc_pin_function_select,
  input wire logic int_osc_enable,
  input wire logic ext_osc_enable,
  input wire logic sysclk_reset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_wr;
    ce && s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_ctrl_wr;
    ce && s_axi_awvalid && s_axi_awready && s_axi_awaddr == HRCS_OFS_CTRL && s_axi_wstrb[0];
  endsequence
  property p_wr_ans;
    s_wr |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
  property p_rd_ans;
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
  property p_ref_tick;
    hf_reference_clock |-> int_osc_tick || ext_osc_tick;
  endproperty
  a_ref_tick: assert property (p_ref_tick) else $error("reference without tick");
  // with the external oscillator off the reference is the internal one
  property p_ref_int;
    !ext_osc_enable |-> hf_reference_clock == int_osc_tick;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("reference not internal");
  // enabling the external oscillator on plain port pins is a fault
  property p_pin_fault;
    s_ctrl_wr ##0 (s_axi_wdata[HRCS_CTRL_EXTEN_BIT] && !s_axi_wdata[HRCS_CTRL_PINSEL_BIT]
      && !ext_osc_enable) |-> ##[1:3] sysclk_reset;
  endproperty
  a_pin_fault: assert property (p_pin_fault) else $error("no clock reset");
  property p_pin_wr;
    s_ctrl_wr |=> sysclk_reset
      || osc_pin_function_select == $past(s_axi_wdata[HRCS_CTRL_PINSEL_BIT]);
  endproperty
  a_pin_wr: assert property (p_pin_wr) else $error("pin select not written");
  property p_rst_pulse;
    sysclk_reset |=> !sysclk_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("clock reset too long");
  property p_rst_ctrl;
    sysclk_reset |-> ##[0:1] (int_osc_enable && !ext_osc_enable && !osc_pin_function_select);
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("control not reset");
endmodule : hrcs_props
bind hrcs_top hrcs_props #(.WU_BITS(WU_BITS), .CMP_BITS(CMP_BITS)) u_props (
  .clk(clk), .rstn(rstn), .ce(ce),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick),
  .hf_reference_clock(hf_reference_clock), .osc_pin_function_select(osc_pin_function_select),
  .int_osc_enable(int_osc_enable), .ext_osc_enable(ext_osc_enable),
  .sysclk_reset(sysclk_reset)
);

// ===== hf_reference_clock_switch_bench.sv
// self-checking bench for the reference clock switch
`timescale 1ns/1ps
module hf_reference_clock_switch_bench;
  import hrcs_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, int_osc_tick = 1'h0, ext_osc_tick = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rb, rr;
  logic [31:0] s_axi_rdata, d, cmp;
  logic hf_reference_clock, osc_pin_function_select, int_osc_enable, ext_osc_enable;
  logic sysclk_reset, warmup_done_interrupt;
  int error_cnt = 0, n_checks = 0, n_rst = 0, n_ext = 0, tick_div = 3;
  hrcs_top uut (
    .clk(clk), .rstn(rstn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick),
    .hf_reference_clock(hf_reference_clock), .osc_pin_function_select(osc_pin_function_select),
    .int_osc_enable(int_osc_enable), .ext_osc_enable(ext_osc_enable),
    .sysclk_reset(sysclk_reset), .warmup_done_interrupt(warmup_done_interrupt)
  );
  initial
  begin
    forever #5 clk = ~clk;
  end
  // random oscillator ticks, clock resets and external ticks counted
  always @(posedge clk)
  begin
    int_osc_tick <= ($urandom % tick_div) == 0;
    ext_osc_tick <= ($urandom % tick_div) == 0;
    if (sysclk_reset === 1'h1) n_rst++;
    if (ext_osc_tick === 1'h1) n_ext++;
  end
  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a <= HRCS_OFS_IRQ_MASK && a[1:0] == 2'h0) ? HRCS_RESP_OKAY : HRCS_RESP_SLVERR;
  endfunction : exp_resp
  function automatic logic [31:0] wu_ok(input int n, input logic [31:0] c);
    return (n + 4 >= c * 64 && n <= c * 64 + 4) ? 32'h1 : 32'h0;
  endfunction : wu_ok
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // sample before the edge so the answer never races the edge updates
  task automatic wait_hi(input int sel);
    logic seen;
    do
    begin
      @(negedge clk);
      case (sel)
        0: seen = s_axi_awready && s_axi_wready;
        1: seen = s_axi_bvalid;
        2: seen = s_axi_arready;
        default: seen = s_axi_rvalid;
      endcase
      d = s_axi_rdata;
      rb = s_axi_bresp;
      rr = s_axi_rresp;
      @(posedge clk);
    end
    while (seen !== 1'h1);
  endtask : wait_hi
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    wait_hi(0);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    wait_hi(1);
    s_axi_bready <= 1'h0;
    chk(rb, exp_resp(a));
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    wait_hi(2);
    s_axi_arvalid <= 1'h0;
    wait_hi(3);
    s_axi_rready <= 1'h0;
    chk(rr, exp_resp(a));
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    do rd(a); while ((d & m) !== v);
  endtask : poll
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(80222));
    cmp = 32'h1 + $urandom % 3;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    rd(HRCS_OFS_CTRL);
    chk(d, 32'h02);
    rd(HRCS_OFS_WUCMP);
    chk(d, 32'h66);
    rd(8'h14);
    chk(d, 32'h0);
    wr(HRCS_OFS_CTRL, 32'h06);
    repeat (4) @(posedge clk);
    chk(n_rst, 1);
    rd(HRCS_OFS_CTRL);
    chk(d, 32'h02);
    chk({ext_osc_enable, int_osc_enable, osc_pin_function_select}, 32'h2);
    rd(HRCS_OFS_IRQ_STATUS);
    chk(d, 32'h2);
    wr(HRCS_OFS_IRQ_STATUS, 32'h2);
    wr(HRCS_OFS_WUCMP, cmp);
    wr(HRCS_OFS_IRQ_MASK, 32'h1);
    wr(HRCS_OFS_CTRL, 32'h03);
    wr(HRCS_OFS_CTRL, 32'h07);
    n_ext = 0;
    repeat (60) @(posedge clk);
    wr(HRCS_OFS_CTRL, 32'h07);
    while (warmup_done_interrupt !== 1'h1) @(posedge clk);
    chk(wu_ok(n_ext, cmp), 32'h1);
    wr(HRCS_OFS_IRQ_STATUS, 32'h1);
    chk(warmup_done_interrupt, 1'h0);
    wr(HRCS_OFS_CTRL, 32'h0F);
    repeat (3) @(posedge clk);
    poll(HRCS_OFS_STATUS, 32'h2, 32'h0);
    chk(d, 32'h1);
    wr(HRCS_OFS_CTRL, 32'h0D);
    wr(HRCS_OFS_CTRL, 32'h1D);
    wr(HRCS_OFS_CTRL, 32'h15);
    rd(HRCS_OFS_CTRL);
    chk(d, 32'h1D);
    wr(HRCS_OFS_CTRL, 32'h0D);
    wr(HRCS_OFS_IRQ_MASK, 32'h0);
    wr(HRCS_OFS_CTRL, 32'h0F);
    poll(HRCS_OFS_IRQ_STATUS, 32'h1, 32'h1);
    chk(warmup_done_interrupt, 1'h0);
    wr(HRCS_OFS_IRQ_MASK, 32'h1);
    chk(warmup_done_interrupt, 1'h1);
    wr(HRCS_OFS_IRQ_STATUS, 32'h1);
    wr(HRCS_OFS_CTRL, 32'h07);
    repeat (3) @(posedge clk);
    poll(HRCS_OFS_STATUS, 32'h2, 32'h0);
    chk(d, 32'h0);
    wr(HRCS_OFS_CTRL, 32'h03);
    chk(n_rst, 1);
    wr(HRCS_OFS_CTRL, 32'h07);
    while (warmup_done_interrupt !== 1'h1) @(posedge clk);
    wr(HRCS_OFS_CTRL, 32'h0F);
    wr(HRCS_OFS_CTRL, 32'h0D);
    repeat (4) @(posedge clk);
    chk(n_rst, 2);
    rd(HRCS_OFS_STATUS);
    chk(d & 32'h1, 32'h0);
    // slow ticks keep the hold-off open long enough to stop the old oscillator in it
    wr(HRCS_OFS_CTRL, 32'h03);
    wr(HRCS_OFS_CTRL, 32'h07);
    tick_div = 128;
    wr(HRCS_OFS_CTRL, 32'h0F);
    poll(HRCS_OFS_STATUS, 32'h3, 32'h3);
    wr(HRCS_OFS_CTRL, 32'h0D);
    repeat (2) @(posedge clk);
    chk(n_rst, 3);
    tick_div = 3;
    repeat (8)
    begin
      @(negedge clk);
      chk(hf_reference_clock, int_osc_tick);
    end
    tally_and_finish();
  end
endmodule : hf_reference_clock_switch_bench
